// >>> pkg/ilp_pkg.sv
// constants and types for interrupt entry and low-power wake control
package ilp_pkg;
    localparam logic [7:0] OPT_ADDR = 8'hC8;
    localparam logic [7:0] OPT_RESET = 8'h00;
    localparam logic [7:0] OPT_USED_MASK = 8'h70;
    localparam int SRC1_LEVEL_BIT = 6;
    localparam int SRC2_POL_BIT = 5;
    localparam int GLOBAL_EN_BIT = 4;
    localparam logic [11:0] VEC_SRC0 = 12'hFFC;
    localparam logic [11:0] VEC_SRC1 = 12'hFF6;
    localparam logic [11:0] VEC_SRC2 = 12'hFF4;
    localparam logic [11:0] VEC_SRC3 = 12'hFF2;
    localparam logic [11:0] VEC_SRC4 = 12'hFF0;
    localparam logic [2:0] SRC_NMI = 3'h0;
    localparam logic [2:0] SRC_1 = 3'h1;
    localparam logic [2:0] SRC_2 = 3'h2;
    localparam logic [2:0] SRC_3 = 3'h3;
    localparam logic [2:0] SRC_4 = 3'h4;
    localparam int NUM_EDGE = 3;
    localparam int STAB_CYCLES = 2048;
    localparam logic [11:0] PC_RESET = 12'h000;

    typedef enum logic [1:0] {
        ILP_FLAGS_NORMAL = 2'h0,
        ILP_FLAGS_INTR = 2'h1,
        ILP_FLAGS_NMI = 2'h2
    } ilp_flags_t;

    typedef enum logic [2:0] {
        ILP_RUN = 3'h0,
        ILP_PUSH = 3'h1,
        ILP_VECT = 3'h3,
        ILP_WAIT = 3'h4,
        ILP_STOP = 3'h2,
        ILP_STAB = 3'h6
    } ilp_state_t;
endpackage

// >>> core/ilp_edge_latch.sv
// edge request latch with selectable polarity and clear
`timescale 1ns/1ns
`default_nettype none
module ilp_edge_latch (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic line_in,
    input wire logic rise_sel,
    input wire logic clr,
    output logic flag
);
    logic prev_reg;
    logic flag_reg;
    logic flag_next;
    wire rise_ev = line_in & ~prev_reg;
    wire fall_ev = ~line_in & prev_reg;
    wire edge_ev = rise_sel ? rise_ev : fall_ev;

    // a new edge wins over the clear
    assign flag_next = edge_ev | (flag_reg & ~clr);
    assign flag = flag_reg;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_reg <= 1'b1;
            flag_reg <= 1'b0;
        end else begin
            prev_reg <= line_in;
            flag_reg <= flag_next;
        end
    end
endmodule
`default_nettype wire

// >>> core/ilp_top.sv
// interrupt entry, return and wait/stop sequencing
`timescale 1ns/1ns
`default_nettype none
module ilp_top #(
    parameter int STAB_CYCLES = ilp_pkg::STAB_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic instr_end,
    input wire logic wait_instr,
    input wire logic stop_instr,
    input wire logic return_from_intr,
    input wire logic [11:0] pc_current,
    input wire logic data_wr,
    input wire logic [7:0] data_addr,
    input wire logic [7:0] data_wdata,
    input wire logic bit_op,
    input wire logic nmi_line_n,
    input wire logic src1_line_n,
    input wire logic src2_line,
    input wire logic timer1_zero_flag,
    input wire logic timer1_intr_enable,
    input wire logic timer2_zero_flag,
    input wire logic timer2_intr_enable,
    input wire logic conv_eoc,
    input wire logic conv_intr_enable,
    input wire logic wdg_hw_option,
    input wire logic wdg_sw_enable,
    output logic core_hold,
    output logic osc_run,
    output logic stack_push,
    output logic [11:0] stack_push_pc,
    output logic stack_pop,
    output logic pc_load,
    output logic [11:0] pc_vector,
    output logic [1:0] flag_set
);
    localparam int STAB_W = $clog2(STAB_CYCLES + 1);
    localparam logic [STAB_W-1:0] STAB_LOAD =
        STAB_W'(STAB_CYCLES - 1);

    ilp_pkg::ilp_state_t state_reg;
    ilp_pkg::ilp_state_t state_next;
    ilp_pkg::ilp_flags_t mode_reg;
    ilp_pkg::ilp_flags_t mode_next;
    ilp_pkg::ilp_flags_t nmi_ret_reg;
    ilp_pkg::ilp_flags_t nmi_ret_next;
    logic [7:0] interrupt_option_reg;
    logic [2:0] src_sel_reg;
    logic [2:0] src_sel_next;
    logic [STAB_W-1:0] stab_cnt_reg;
    logic [STAB_W-1:0] stab_cnt_next;
    logic core_hold_reg;
    logic osc_run_reg;
    logic stack_push_reg;
    logic [11:0] stack_push_pc_reg;
    logic stack_pop_reg;
    logic pc_load_reg;
    logic [11:0] pc_vector_reg;
    logic [1:0] flag_set_reg;
    logic [ilp_pkg::NUM_EDGE-1:0] edge_line;
    logic [ilp_pkg::NUM_EDGE-1:0] edge_rise;
    logic [ilp_pkg::NUM_EDGE-1:0] edge_clr;
    logic [ilp_pkg::NUM_EDGE-1:0] edge_flag;

    // option register fields
    wire global_intr_enable = interrupt_option_reg[ilp_pkg::GLOBAL_EN_BIT];
    wire src1_level_select = interrupt_option_reg[ilp_pkg::SRC1_LEVEL_BIT];
    wire src2_edge_polarity = interrupt_option_reg[ilp_pkg::SRC2_POL_BIT];

    // full-byte writes only; bit operations leave it alone
    wire opt_wr = data_wr & (data_addr == ilp_pkg::OPT_ADDR) & ~bit_op;

    // edge latches: nmi, source 1, source 2
    assign edge_line = {src2_line, src1_line_n, nmi_line_n};
    assign edge_rise = {src2_edge_polarity, 1'b0, 1'b0};

    genvar gi;
    generate
        for (gi = 0; gi < ilp_pkg::NUM_EDGE; gi++) begin : g_edge
            ilp_edge_latch u_latch (
                .ref_clk(ref_clk),
                .rst_n(rst_n),
                .line_in(edge_line[gi]),
                .rise_sel(edge_rise[gi]),
                .clr(edge_clr[gi]),
                .flag(edge_flag[gi])
            );
        end
    endgenerate

    // source requests
    wire req1 = src1_level_select ? ~src1_line_n : edge_flag[1];
    wire req2 = edge_flag[2];
    wire req3 = (timer1_zero_flag & timer1_intr_enable)
              | (timer2_zero_flag & timer2_intr_enable);
    wire req4 = conv_eoc & conv_intr_enable;
    wire mask_any = req1 | req2 | req3 | req4;

    // acceptance and priority
    wire nmi_ok = edge_flag[0] & (mode_reg != ilp_pkg::ILP_FLAGS_NMI);
    wire mask_ok = global_intr_enable & mask_any
                 & (mode_reg == ilp_pkg::ILP_FLAGS_NORMAL);
    wire accept = nmi_ok | mask_ok;
    wire [2:0] src_pick = nmi_ok ? ilp_pkg::SRC_NMI :
                          req1 ? ilp_pkg::SRC_1 :
                          req2 ? ilp_pkg::SRC_2 :
                          req3 ? ilp_pkg::SRC_3 : ilp_pkg::SRC_4;

    // any enabled request; also the wake condition
    wire pend_enabled = global_intr_enable & (edge_flag[0] | mask_any);
    wire wdg_on = wdg_hw_option | wdg_sw_enable;
    wire lp_go = instr_end & (wait_instr | stop_instr)
               & ~pend_enabled;
    wire stop_go = lp_go & stop_instr & ~wdg_on;
    wire run_st = state_reg == ilp_pkg::ILP_RUN;
    wire return_from_intr_go = return_from_intr & run_st;

    // next state
    always_comb begin
        state_next = state_reg;
        stab_cnt_next = stab_cnt_reg;
        case (state_reg)
            ilp_pkg::ILP_RUN: begin
                if (instr_end && accept) begin
                    state_next = ilp_pkg::ILP_PUSH;
                end else if (stop_go) begin
                    state_next = ilp_pkg::ILP_STOP;
                end else if (lp_go) begin
                    state_next = ilp_pkg::ILP_WAIT;
                end
            end
            ilp_pkg::ILP_PUSH: begin
                state_next = ilp_pkg::ILP_VECT;
            end
            ilp_pkg::ILP_VECT: begin
                state_next = ilp_pkg::ILP_RUN;
            end
            ilp_pkg::ILP_WAIT: begin
                if (pend_enabled) begin
                    // no stabilisation wait here
                    state_next = accept ? ilp_pkg::ILP_PUSH
                                        : ilp_pkg::ILP_RUN;
                end
            end
            ilp_pkg::ILP_STOP: begin
                if (pend_enabled) begin
                    state_next = ilp_pkg::ILP_STAB;
                    stab_cnt_next = STAB_LOAD;
                end
            end
            ilp_pkg::ILP_STAB: begin
                if (stab_cnt_reg == '0) begin
                    state_next = accept ? ilp_pkg::ILP_PUSH
                                        : ilp_pkg::ILP_RUN;
                end else begin
                    stab_cnt_next = stab_cnt_reg - 1'b1;
                end
            end
            default: begin
                state_next = ilp_pkg::ILP_RUN;
            end
        endcase
    end

    wire go_push = (state_next == ilp_pkg::ILP_PUSH)
                 & (state_reg != ilp_pkg::ILP_PUSH);

    // latch clear on entry
    generate
        for (gi = 0; gi < ilp_pkg::NUM_EDGE; gi++) begin : g_clr
            assign edge_clr[gi] = go_push & (src_pick == 3'(gi));
        end
    endgenerate

    // flag set switching and return
    always_comb begin
        mode_next = mode_reg;
        nmi_ret_next = nmi_ret_reg;
        if (go_push && nmi_ok) begin
            mode_next = ilp_pkg::ILP_FLAGS_NMI;
            nmi_ret_next = mode_reg;
        end else if (go_push) begin
            mode_next = ilp_pkg::ILP_FLAGS_INTR;
        end else if (return_from_intr_go) begin
            if (mode_reg == ilp_pkg::ILP_FLAGS_NMI) begin
                mode_next = nmi_ret_reg;
            end else begin
                mode_next = ilp_pkg::ILP_FLAGS_NORMAL;
            end
        end
    end

    assign src_sel_next = go_push ? src_pick : src_sel_reg;
    wire [11:0] vec_sel =
        (src_sel_reg == ilp_pkg::SRC_NMI) ? ilp_pkg::VEC_SRC0 :
        (src_sel_reg == ilp_pkg::SRC_1) ? ilp_pkg::VEC_SRC1 :
        (src_sel_reg == ilp_pkg::SRC_2) ? ilp_pkg::VEC_SRC2 :
        (src_sel_reg == ilp_pkg::SRC_3) ? ilp_pkg::VEC_SRC3 :
        ilp_pkg::VEC_SRC4;
    wire [7:0] opt_next = data_wdata & ilp_pkg::OPT_USED_MASK;

    // reset clears everything back to run
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ilp_pkg::ILP_RUN;
            mode_reg <= ilp_pkg::ILP_FLAGS_NORMAL;
            nmi_ret_reg <= ilp_pkg::ILP_FLAGS_NORMAL;
            src_sel_reg <= ilp_pkg::SRC_NMI;
            stab_cnt_reg <= '0;
        end else begin
            state_reg <= state_next;
            mode_reg <= mode_next;
            nmi_ret_reg <= nmi_ret_next;
            src_sel_reg <= src_sel_next;
            stab_cnt_reg <= stab_cnt_next;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            interrupt_option_reg <= ilp_pkg::OPT_RESET;
        end else if (opt_wr) begin
            interrupt_option_reg <= opt_next;
        end
    end

    // registered core-side outputs
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            core_hold_reg <= 1'b0;
            osc_run_reg <= 1'b1;
            stack_push_reg <= 1'b0;
            stack_push_pc_reg <= ilp_pkg::PC_RESET;
            stack_pop_reg <= 1'b0;
            pc_load_reg <= 1'b0;
            pc_vector_reg <= ilp_pkg::PC_RESET;
            flag_set_reg <= ilp_pkg::ILP_FLAGS_NORMAL;
        end else begin
            core_hold_reg <= state_next != ilp_pkg::ILP_RUN;
            osc_run_reg <= state_next != ilp_pkg::ILP_STOP;
            stack_push_reg <= go_push;
            if (go_push) begin
                stack_push_pc_reg <= pc_current;
            end
            stack_pop_reg <= return_from_intr_go;
            pc_load_reg <= state_reg == ilp_pkg::ILP_PUSH;
            if (state_reg == ilp_pkg::ILP_PUSH) begin
                pc_vector_reg <= vec_sel;
            end
            flag_set_reg <= mode_next;
        end
    end

    assign core_hold = core_hold_reg;
    assign osc_run = osc_run_reg;
    assign stack_push = stack_push_reg;
    assign stack_push_pc = stack_push_pc_reg;
    assign stack_pop = stack_pop_reg;
    assign pc_load = pc_load_reg;
    assign pc_vector = pc_vector_reg;
    assign flag_set = flag_set_reg;

    // checks
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_entry;
        stack_push_reg ##1 pc_load_reg;
    endsequence

    chk_entry_order: assert property (
        go_push |=> s_entry
    ) else $error("entry push and vector load out of order");

    chk_vector_src3: assert property (
        stack_push_reg && src_sel_reg == ilp_pkg::SRC_3
        |=> pc_vector_reg == ilp_pkg::VEC_SRC3
    ) else $error("wrong vector for source 3");

    chk_nmi_flagset: assert property (
        go_push && nmi_ok
        |=> flag_set_reg == ilp_pkg::ILP_FLAGS_NMI && stack_push_reg
    ) else $error("nmi entry did not select nmi flag set");

    chk_mask_inhibit: assert property (
        run_st && instr_end && !nmi_ok
        && mode_reg != ilp_pkg::ILP_FLAGS_NORMAL |=> !stack_push_reg
    ) else $error("maskable request taken inside a routine");

    chk_nmi_latch_clr: assert property (
        go_push && nmi_ok && nmi_line_n |=> !edge_flag[0]
    ) else $error("nmi latch not cleared on entry");

    chk_opt_write: assert property (
        opt_wr |=> interrupt_option_reg
            == ($past(data_wdata) & ilp_pkg::OPT_USED_MASK)
    ) else $error("option register write lost");

    chk_bitop_ignored: assert property (
        data_wr && bit_op |=> $stable(interrupt_option_reg)
    ) else $error("bit operation altered option register");

    chk_stop_as_wait: assert property (
        run_st && !accept && lp_go && stop_instr && wdg_on
        |=> state_reg == ilp_pkg::ILP_WAIT && osc_run_reg
    ) else $error("stop with watchdog on did not become wait");

    chk_stop_stab: assert property (
        state_reg == ilp_pkg::ILP_STOP && pend_enabled
        |=> state_reg == ilp_pkg::ILP_STAB ##1 core_hold_reg
    ) else $error("stop wake skipped stabilisation");

    chk_wait_no_delay: assert property (
        state_reg == ilp_pkg::ILP_WAIT && pend_enabled
        |=> state_reg != ilp_pkg::ILP_STAB
    ) else $error("wait wake inserted delay");

    chk_wake_blocked: assert property (
        state_reg == ilp_pkg::ILP_WAIT && !global_intr_enable
        |=> state_reg == ilp_pkg::ILP_WAIT
    ) else $error("woke with global enable clear");

    chk_lp_refused: assert property (
        run_st && instr_end && wait_instr && pend_enabled
        |=> state_reg != ilp_pkg::ILP_WAIT
    ) else $error("wait executed with request pending");
endmodule
`default_nettype wire

// >>> bench/ilp_core_model.sv
// core sequencer model: program counter and hardware stack
`timescale 1ns/1ns
`default_nettype none
module ilp_core_model (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic instr_end,
    input wire logic core_hold,
    input wire logic stack_push,
    input wire logic [11:0] stack_push_pc,
    input wire logic stack_pop,
    input wire logic pc_load,
    input wire logic [11:0] pc_vector,
    output logic [11:0] pc_now
);
    logic [11:0] stk [0:3];
    logic [1:0] sp;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pc_now <= 12'h000;
            sp <= 2'h0;
        end else begin
            if (stack_push) begin
                stk[sp] <= stack_push_pc;
                sp <= sp + 2'h1;
            end else if (stack_pop) begin
                sp <= sp - 2'h1;
            end
            if (pc_load) begin
                pc_now <= pc_vector;
            end else if (stack_pop) begin
                pc_now <= stk[sp - 2'h1];
            end else if (instr_end && !core_hold) begin
                pc_now <= pc_now + 12'h001;
            end
        end
    end
endmodule
`default_nettype wire

// >>> bench/intr_entry_and_low_power_wake_tb.sv
// self-checking bench for interrupt entry and wait/stop control
`timescale 1ns/1ns
`default_nettype none
module intr_entry_and_low_power_wake_tb;
    localparam int STAB = 4;
    logic ref_clk, rst_n, instr_end, wait_instr, stop_instr, return_from_intr;
    logic data_wr, bit_op, nmi_line_n, src1_line_n, src2_line;
    logic timer1_zero_flag, timer1_intr_enable, timer2_zero_flag;
    logic timer2_intr_enable, conv_eoc, conv_intr_enable;
    logic wdg_hw_option, wdg_sw_enable, core_hold, osc_run;
    logic stack_push, stack_pop, pc_load;
    logic [7:0] data_addr, data_wdata;
    logic [11:0] pc_current, stack_push_pc, pc_vector, last_pc, p;
    logic [1:0] flag_set;
    int n_errors = 0, total_checks = 0, cycles = 0, n;

    ilp_top #(.STAB_CYCLES(STAB)) uut (.ref_clk(ref_clk), .rst_n(rst_n),
        .instr_end(instr_end), .wait_instr(wait_instr),
        .stop_instr(stop_instr), .return_from_intr(return_from_intr),
        .pc_current(pc_current), .data_wr(data_wr), .data_addr(data_addr),
        .data_wdata(data_wdata), .bit_op(bit_op), .nmi_line_n(nmi_line_n),
        .src1_line_n(src1_line_n), .src2_line(src2_line),
        .timer1_zero_flag(timer1_zero_flag),
        .timer1_intr_enable(timer1_intr_enable),
        .timer2_zero_flag(timer2_zero_flag),
        .timer2_intr_enable(timer2_intr_enable), .conv_eoc(conv_eoc),
        .conv_intr_enable(conv_intr_enable), .wdg_hw_option(wdg_hw_option),
        .wdg_sw_enable(wdg_sw_enable), .core_hold(core_hold),
        .osc_run(osc_run), .stack_push(stack_push),
        .stack_push_pc(stack_push_pc), .stack_pop(stack_pop),
        .pc_load(pc_load), .pc_vector(pc_vector), .flag_set(flag_set));
    ilp_core_model core (.ref_clk(ref_clk), .rst_n(rst_n),
        .instr_end(instr_end), .core_hold(core_hold),
        .stack_push(stack_push), .stack_push_pc(stack_push_pc),
        .stack_pop(stack_pop), .pc_load(pc_load), .pc_vector(pc_vector),
        .pc_now(pc_current));

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic check(input string nm, input logic [11:0] e,
                         input logic [11:0] g);
        total_checks++;
        if (g !== e) begin
            $display("wrong value %s expected %h seen %h", nm, e, g);
            n_errors++;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d,
                      input logic b);
        @(negedge ref_clk);
        data_wr = 1'b1;
        data_addr = a;
        data_wdata = d;
        bit_op = b;
        @(negedge ref_clk);
        data_wr = 1'b0;
        bit_op = 1'b0;
    endtask
    task automatic instr(input logic w, input logic s);
        @(negedge ref_clk);
        last_pc = pc_current;
        instr_end = 1'b1;
        wait_instr = w;
        stop_instr = s;
        @(negedge ref_clk);
        instr_end = 1'b0;
        wait_instr = 1'b0;
        stop_instr = 1'b0;
    endtask
    task automatic no_entry();
        repeat (3) begin
            @(negedge ref_clk);
            check("stack_push", 1'b0, stack_push);
        end
    endtask
    task automatic entry(input logic [11:0] vec, input logic [1:0] fs,
                         input int lim, input logic [11:0] pc);
        n = 0;
        while (stack_push !== 1'b1 && n < lim) begin
            @(negedge ref_clk);
            n++;
        end
        check("stack_push", 1'b1, stack_push);
        check("stack_push_pc", pc, stack_push_pc);
        check("flag_set", fs, flag_set);
        @(negedge ref_clk);
        check("pc_load", 1'b1, pc_load);
        check("pc_vector", vec, pc_vector);
    endtask
    task automatic ret(input logic [1:0] fs, input logic [11:0] pc);
        @(negedge ref_clk);
        return_from_intr = 1'b1;
        @(negedge ref_clk);
        return_from_intr = 1'b0;
        check("stack_pop", 1'b1, stack_pop);
        check("flag_set", fs, flag_set);
        @(negedge ref_clk);
        check("pc_now", pc, pc_current);
    endtask

    task automatic t_option_reg();
        check("flag_set", 2'h0, flag_set);
        check("osc_run", 1'b1, osc_run);
        timer1_zero_flag = 1'b1;
        instr(1'b0, 1'b0);
        no_entry();
        wr(8'hC8, 8'h10, 1'b1);
        instr(1'b0, 1'b0);
        no_entry();
        wr(8'hC9, 8'h10, 1'b0);
        wr(8'hC8, 8'h8F, 1'b0);
        instr(1'b0, 1'b0);
        no_entry();
        wr(8'hC8, 8'h10, 1'b0);
        timer1_intr_enable = 1'b0;
        instr(1'b0, 1'b0);
        no_entry();
        timer1_intr_enable = 1'b1;
        instr(1'b0, 1'b0);
        p = last_pc;
        entry(12'hFF2, 2'h1, 4, p);
        timer1_zero_flag = 1'b0;
        ret(2'h0, p);
        $display("test option_reg done");
    endtask
    task automatic t_nesting();
        logic [11:0] q;
        conv_eoc = 1'b1;
        instr(1'b0, 1'b0);
        q = last_pc;
        entry(12'hFF0, 2'h1, 4, q);
        instr(1'b0, 1'b0);
        no_entry();
        nmi_line_n = 1'b0;
        instr(1'b0, 1'b0);
        p = last_pc;
        entry(12'hFFC, 2'h2, 4, p);
        nmi_line_n = 1'b1;
        ret(2'h1, p);
        instr(1'b0, 1'b0);
        no_entry();
        conv_eoc = 1'b0;
        ret(2'h0, q);
        $display("test nesting done");
    endtask
    task automatic t_src_modes();
        wr(8'hC8, 8'h30, 1'b0);
        src2_line = 1'b0;
        instr(1'b0, 1'b0);
        no_entry();
        src2_line = 1'b1;
        instr(1'b0, 1'b0);
        p = last_pc;
        entry(12'hFF4, 2'h1, 4, p);
        ret(2'h0, p);
        wr(8'hC8, 8'h10, 1'b0);
        src2_line = 1'b0;
        @(negedge ref_clk);
        src2_line = 1'b1;
        instr(1'b0, 1'b0);
        p = last_pc;
        entry(12'hFF4, 2'h1, 4, p);
        ret(2'h0, p);
        src1_line_n = 1'b0;
        @(negedge ref_clk);
        src1_line_n = 1'b1;
        instr(1'b0, 1'b0);
        p = last_pc;
        entry(12'hFF6, 2'h1, 4, p);
        ret(2'h0, p);
        wr(8'hC8, 8'h50, 1'b0);
        src1_line_n = 1'b0;
        instr(1'b0, 1'b0);
        p = last_pc;
        entry(12'hFF6, 2'h1, 4, p);
        src1_line_n = 1'b1;
        ret(2'h0, p);
        $display("test src_modes done");
    endtask
    task automatic t_low_power();
        wr(8'hC8, 8'h10, 1'b0);
        instr(1'b1, 1'b0);
        p = last_pc + 12'h001;
        repeat (4) @(negedge ref_clk);
        check("core_hold", 1'b1, core_hold);
        check("osc_run", 1'b1, osc_run);
        timer2_zero_flag = 1'b1;
        entry(12'hFF2, 2'h1, 2, p);
        timer2_zero_flag = 1'b0;
        ret(2'h0, p);
        instr(1'b0, 1'b1);
        p = last_pc + 12'h001;
        @(negedge ref_clk);
        check("osc_run", 1'b0, osc_run);
        timer2_zero_flag = 1'b1;
        entry(12'hFF2, 2'h1, 20, p);
        check("stab_long", 1'b1, n >= STAB);
        timer2_zero_flag = 1'b0;
        ret(2'h0, p);
        wdg_sw_enable = 1'b1;
        instr(1'b0, 1'b1);
        p = last_pc + 12'h001;
        @(negedge ref_clk);
        check("osc_run", 1'b1, osc_run);
        check("core_hold", 1'b1, core_hold);
        conv_eoc = 1'b1;
        entry(12'hFF0, 2'h1, 2, p);
        conv_eoc = 1'b0;
        ret(2'h0, p);
        timer2_zero_flag = 1'b1;
        instr(1'b1, 1'b0);
        p = last_pc;
        entry(12'hFF2, 2'h1, 4, p);
        timer2_zero_flag = 1'b0;
        ret(2'h0, p);
        $display("test low_power done");
    endtask
    task automatic t_nested_wait();
        logic [11:0] q;
        {wdg_hw_option, wdg_sw_enable} = 2'h2;
        nmi_line_n = 1'b0;
        @(negedge ref_clk);
        nmi_line_n = 1'b1;
        instr(1'b0, 1'b0);
        q = last_pc;
        entry(12'hFFC, 2'h2, 4, q);
        instr(1'b0, 1'b1);
        check("osc_run", 1'b1, osc_run);
        conv_eoc = 1'b1;
        no_entry();
        check("core_hold", 1'b0, core_hold);
        check("flag_set", 2'h2, flag_set);
        conv_eoc = 1'b0;
        ret(2'h0, q);
        conv_eoc = 1'b1;
        instr(1'b0, 1'b0);
        q = last_pc;
        entry(12'hFF0, 2'h1, 4, q);
        conv_eoc = 1'b0;
        instr(1'b1, 1'b0);
        p = last_pc + 12'h001;
        nmi_line_n = 1'b0;
        @(negedge ref_clk);
        nmi_line_n = 1'b1;
        entry(12'hFFC, 2'h2, 4, p);
        ret(2'h1, p);
        instr(1'b1, 1'b0);
        conv_eoc = 1'b1;
        no_entry();
        check("flag_set", 2'h1, flag_set);
        conv_eoc = 1'b0;
        ret(2'h0, q);
        {wdg_hw_option, wdg_sw_enable} = 2'h0;
        $display("test nested_wait done");
    endtask
    task automatic t_global_off();
        wr(8'hC8, 8'h00, 1'b0);
        nmi_line_n = 1'b0;
        instr(1'b0, 1'b0);
        p = last_pc;
        entry(12'hFFC, 2'h2, 4, p);
        nmi_line_n = 1'b1;
        ret(2'h0, p);
        instr(1'b1, 1'b0);
        nmi_line_n = 1'b0;
        no_entry();
        check("core_hold", 1'b1, core_hold);
        nmi_line_n = 1'b1;
        @(negedge ref_clk);
        rst_n = 1'b0;
        @(negedge ref_clk);
        check("core_hold", 1'b0, core_hold);
        check("flag_set", 2'h0, flag_set);
        rst_n = 1'b1;
        $display("test global_off done");
    endtask

    initial begin
        rst_n = 1'b0;
        {instr_end, wait_instr, stop_instr, return_from_intr} = 4'h0;
        {data_wr, bit_op, data_addr, data_wdata} = 18'h00000;
        {nmi_line_n, src1_line_n, src2_line} = 3'h7;
        {timer1_zero_flag, timer1_intr_enable} = 2'h1;
        {timer2_zero_flag, timer2_intr_enable} = 2'h1;
        {conv_eoc, conv_intr_enable} = 2'h1;
        {wdg_hw_option, wdg_sw_enable} = 2'h0;
        repeat (5) @(posedge ref_clk);
        @(negedge ref_clk);
        rst_n = 1'b1;
        t_option_reg();
        t_nesting();
        t_src_modes();
        t_low_power();
        t_nested_wait();
        t_global_off();
        wrap_up();
    end
endmodule
`default_nettype wire
